// ===== src/fp_operand_classifier.sv
// operand decoder and classifier for single and double words, widened to the internal extended format
// assumes a single 250 MHz clock, operands from logic on the same clock, no software registers
`timescale 1ns/1ps
`include "fp_classify_params.svh"

// What this block does
// - single operands arrive as 32-bit words, double as 64-bit words
// - single: fraction bits 0-22, exponent bits 23-30, sign bit 31
// - single exponent biased by 127; normalized true exponents span -126 to 127
// - sign one means negative, zero means positive, both formats
// - normalized single gets hidden bit one above fraction bit 22
// - double: fraction bits 0-51, exponent bits 52-62, sign bit 63
// - double exponent biased by 1023; normalized true exponents span -1022 to 1023
// - normalized double gets hidden bit one above fraction bit 51
// - exponent neither all zeros nor all ones means normalized
// - zero exponent, nonzero fraction means denormalized with hidden bit zero
// - zero exponent, zero fraction means signed zero
// - all-ones exponent, zero fraction means signed infinity
// - all-ones exponent, nonzero fraction is NaN; top fraction bit picks trapping or not
// - produced nontrapping NaN has every fraction bit set
// - the block never produces a trapping NaN
// - operands widen to double-extended on entry with no precision lost
module fp_operand_classifier
    import fp_classify_pkg::*;
(
    input  wire logic                       clk,
    input  wire logic                       rst_b,
    input  wire logic                       operand_valid,
    input  wire fp_classify_pkg::fp_format_t operand_format,
    input  wire logic [63:0]                operand_word,
    input  wire logic                       nan_sign,
    output logic                            result_valid,
    output logic                            sign,
    output logic [10:0]                     biased_exponent,
    output logic [52:0]                     significand,
    output logic [14:0]                     ext_exponent,
    output logic [63:0]                     ext_significand,
    output fp_classify_pkg::fp_class_t      operand_class,
    output logic                            is_zero,
    output logic                            is_denorm,
    output logic                            is_norm,
    output logic                            is_inf,
    output logic                            is_trap_nan,
    output logic                            is_quiet_nan,
    output logic [31:0]                     sgl_default_nan,
    output logic [63:0]                     dbl_default_nan
);
    import fp_classify_pkg::*;

    // flow: split the word by format, test the exponent extremes, pick the class, then build the
    // restored significand and the widened extended copy; everything lands in one register stage
    // so the arithmetic side sees a complete, consistent operand one clock after it was presented

    // exponent extremes are tested at the width of the format in use; a single exponent arrives
    // zero-extended, so the mask keeps its three spare bits out of the all-ones test
    function automatic logic exp_is_min(input logic is_double, input logic [10:0] exp_field);
        logic [10:0] mask;
        mask = is_double ? 11'h7ff : 11'h0ff;
        return (exp_field & mask) == 11'h000;
    endfunction

    function automatic logic exp_is_max(input logic is_double, input logic [10:0] exp_field);
        logic [10:0] mask;
        mask = is_double ? 11'h7ff : 11'h0ff;
        return (exp_field & mask) == mask;
    endfunction

    // moves a biased exponent to the extended bias; the difference may wrap below zero, but the
    // final sum is always positive and fits 15 bits, so the cut keeps the exact value
    function automatic logic [14:0] to_ext_exp(input logic [14:0] exp_field, input logic [14:0] bias);
        return 15'(exp_field - bias + `EXT_BIAS);
    endfunction

    // field split per format; a single operand sits in the low word
    wire logic        sgl_sign = operand_word[`SGL_SIGN_BIT];
    wire logic [7:0]  sgl_exp  = operand_word[`SGL_EXP_MSB:`SGL_EXP_LSB];
    wire logic [22:0] sgl_frac = operand_word[`SGL_FRAC_MSB:0];
    wire logic        dbl_sign = operand_word[`DBL_SIGN_BIT];
    wire logic [10:0] dbl_exp  = operand_word[`DBL_EXP_MSB:`DBL_EXP_LSB];
    wire logic [51:0] dbl_frac = operand_word[`DBL_FRAC_MSB:0];

    wire logic        is_dbl   = (operand_format == fmt_double);

    wire logic        in_sign  = is_dbl ? dbl_sign : sgl_sign;
    wire logic [10:0] in_exp   = is_dbl ? dbl_exp : {3'h0, sgl_exp};
    // single fraction left-aligned so its top bit lands where the double one does
    wire logic [51:0] in_frac  = is_dbl ? dbl_frac : {sgl_frac, 29'h0};

    wire logic exp_min  = exp_is_min(is_dbl, in_exp);
    wire logic exp_max  = exp_is_max(is_dbl, in_exp);
    wire logic frac_nz  = |in_frac;
    wire logic frac_top = in_frac[51];

    // exactly one of these is ever high, so the class is one-hot by construction
    wire logic c_norm   = !exp_min && !exp_max;
    wire logic c_denorm = exp_min && frac_nz;
    wire logic c_zero   = exp_min && !frac_nz;
    wire logic c_inf    = exp_max && !frac_nz;
    wire logic c_qnan   = exp_max && frac_top;
    wire logic c_tnan   = exp_max && frac_nz && !frac_top;

    wire fp_class_t next_class = c_norm   ? class_norm :
                                 c_denorm ? class_denorm :
                                 c_zero   ? class_zero :
                                 c_inf    ? class_inf :
                                 c_qnan   ? class_quiet_nan : class_trap_nan;

    // hidden bit is one only for normalized values
    wire logic        hidden       = c_norm;
    wire logic [52:0] next_signif  = {hidden, in_frac};

    // rebias to extended: true exponent is exp - bias; denormals use exponent 1 - bias
    wire logic [14:0] eff_exp      = c_denorm ? 15'h0001 : {4'h0, in_exp};
    // two adders with constant bias instead of one adder behind a bias select
    wire logic [14:0] sgl_ext_exp  = to_ext_exp(eff_exp, `SGL_BIAS);
    wire logic [14:0] dbl_ext_exp  = to_ext_exp(eff_exp, `DBL_BIAS);
    // zero keeps exponent zero and inf or NaN saturate, so the special classes survive widening
    wire logic [14:0] next_ext_exp = c_zero ? 15'h0000 :
                                     exp_max ? `EXT_EXP_MAX :
                                     is_dbl ? dbl_ext_exp : sgl_ext_exp;
    // explicit bit carries the hidden bit; a denormal stays unnormalized so no bit is lost
    wire logic [63:0] next_ext_sig = {hidden, in_frac, 11'h000};

    // one pulse per presented operand; a caller may present every cycle, since the answer
    // needs no second stage and nothing is ever refused
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            result_valid <= 1'b0;
        end else begin
            result_valid <= operand_valid;
        end
    end

    // class flags are decoded ahead of the register so they leave the block from flip-flops;
    // each flag matches one class code, so no two can be high together
    wire logic [5:0] next_flags;
    logic      [5:0] class_flags;

    for (genvar k = 0; k < 6; k++) begin : g_flag
        assign next_flags[k] = (next_class == 3'(k));
    end

    // datapath captured only on a presented operand; every field follows the same edge
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sign            <= 1'b0;
            biased_exponent <= 11'h000;
        end else if (operand_valid) begin
            sign            <= in_sign;
            biased_exponent <= in_exp;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            significand <= 53'h0;
        end else if (operand_valid) begin
            significand <= next_signif;
        end
    end

    // the widened copy is what the arithmetic side consumes; it holds with the other fields
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ext_exponent    <= 15'h0000;
            ext_significand <= `OPERAND_RESET;
        end else if (operand_valid) begin
            ext_exponent    <= next_ext_exp;
            ext_significand <= next_ext_sig;
        end
    end

    // reset leaves the class at zero, matching the cleared datapath fields
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            operand_class <= class_zero;
            class_flags   <= `FLAGS_RESET;
        end else if (operand_valid) begin
            operand_class <= next_class;
            class_flags   <= next_flags;
        end
    end

    assign is_zero      = class_flags[0];
    assign is_denorm    = class_flags[1];
    assign is_norm      = class_flags[2];
    assign is_inf       = class_flags[3];
    assign is_trap_nan  = class_flags[4];
    assign is_quiet_nan = class_flags[5];

    // default NaN: all fraction bits set, so its top bit is one and it can never trap;
    // the sign is the only free bit and it follows nan_sign one clock late
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sgl_default_nan <= `SGL_DEFAULT_NAN;
        end else begin
            sgl_default_nan <= {nan_sign, 31'(`SGL_DEFAULT_NAN)};
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dbl_default_nan <= `DBL_DEFAULT_NAN;
        end else begin
            dbl_default_nan <= {nan_sign, 63'(`DBL_DEFAULT_NAN)};
        end
    end

endmodule // fp_operand_classifier

// ===== src/fp_classify_params.svh
// field positions, biases and fixed patterns of the single and double operand formats
// assumes inclusion from the classifier module only
`ifndef FP_CLASSIFY_PARAMS_SVH
`define FP_CLASSIFY_PARAMS_SVH

`define SGL_FRAC_MSB      22
`define SGL_EXP_LSB       23
`define SGL_EXP_MSB       30
`define SGL_SIGN_BIT      31
`define SGL_BIAS          15'h007f
`define DBL_FRAC_MSB      51
`define DBL_EXP_LSB       52
`define DBL_EXP_MSB       62
`define DBL_SIGN_BIT      63
`define DBL_BIAS          15'h03ff
`define EXT_BIAS          15'h3fff
`define EXT_EXP_MAX       15'h7fff
`define SGL_DEFAULT_NAN   32'h7fff_ffff
`define DBL_DEFAULT_NAN   64'h7fff_ffff_ffff_ffff
`define OPERAND_RESET     64'h0000_0000_0000_0000
`define FLAGS_RESET       6'h01

`endif

// ===== src/fp_classify_pkg.sv
// types shared by the operand classifier and whoever instantiates it
// assumes fp_classify_params.svh is on the include path
package fp_classify_pkg;
    typedef enum logic [2:0] {
        class_zero      = 3'h0,
        class_denorm    = 3'h1,
        class_norm      = 3'h2,
        class_inf       = 3'h3,
        class_trap_nan  = 3'h4,
        class_quiet_nan = 3'h5
    } fp_class_t;

    typedef enum logic {
        fmt_single = 1'b0,
        fmt_double = 1'b1
    } fp_format_t;
endpackage

// ===== test/fp_classifier_chk.sv
// port-level checks on the operand classifier
// assumes bind to fp_operand_classifier, one clock domain
`timescale 1ns/1ps
module fp_classifier_chk
    import fp_classify_pkg::*;
(
    input wire logic                         clk,
    input wire logic                         rst_b,
    input wire logic                         operand_valid,
    input wire fp_classify_pkg::fp_format_t  operand_format,
    input wire logic [63:0]                  operand_word,
    input wire logic                         nan_sign,
    input wire logic                         result_valid,
    input wire logic                         sign,
    input wire logic [10:0]                  biased_exponent,
    input wire logic [52:0]                  significand,
    input wire logic [14:0]                  ext_exponent,
    input wire logic [63:0]                  ext_significand,
    input wire fp_classify_pkg::fp_class_t   operand_class,
    input wire logic                         is_zero,
    input wire logic                         is_denorm,
    input wire logic                         is_norm,
    input wire logic                         is_inf,
    input wire logic                         is_trap_nan,
    input wire logic                         is_quiet_nan,
    input wire logic [31:0]                  sgl_default_nan,
    input wire logic [63:0]                  dbl_default_nan
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence take_s; operand_valid; endsequence
    sequence sgl_zero_s; take_s ##0 (operand_format == fmt_single && operand_word[30:0] == 31'h0); endsequence
    sequence dbl_mid_s; take_s ##0 (operand_format == fmt_double && operand_word[62:52] != 11'h0
        && operand_word[62:52] != 11'h7ff); endsequence
    a_valid_once: assert property (result_valid == $past(operand_valid)) else $error("result valid off");
    a_sign_pick: assert property (take_s |=> sign == $past(operand_format ? operand_word[63] : operand_word[31]))
        else $error("sign bit wrong");
    a_exp_field: assert property (take_s |=> biased_exponent
        == $past(operand_format ? operand_word[62:52] : {3'h0, operand_word[30:23]})) else $error("exponent wrong");
    a_one_flag: assert property ($onehot({is_zero, is_denorm, is_norm, is_inf, is_trap_nan, is_quiet_nan}))
        else $error("class flags not one-hot");
    a_hidden_bit: assert property (take_s |=> significand[52] == is_norm) else $error("hidden bit wrong");
    a_nan_split: assert property ((is_trap_nan || is_quiet_nan) |-> significand[51] == is_quiet_nan)
        else $error("nan kind wrong");
    a_zero_class: assert property (sgl_zero_s |=> is_zero) else $error("zero not classed");
    a_norm_class: assert property (dbl_mid_s |=> is_norm) else $error("normal not classed");
    a_nan_pattern: assert property ($past(rst_b) |-> sgl_default_nan == {$past(nan_sign), 31'h7fff_ffff}
        && dbl_default_nan == {$past(nan_sign), 63'h7fff_ffff_ffff_ffff}) else $error("default nan wrong");
    a_data_hold: assert property (!operand_valid |=> $stable(significand) && $stable(operand_class))
        else $error("data moved while idle");
    a_wide_special: assert property ((is_inf || is_trap_nan || is_quiet_nan) |-> ext_exponent == 15'h7fff)
        else $error("special exponent not saturated");
    a_wide_bits: assert property (take_s |=> ext_significand[63:11] == significand)
        else $error("widened significand lost bits");
    a_nan_quiet: assert property (sgl_default_nan[22] && dbl_default_nan[51])
        else $error("default nan would trap");
endmodule // fp_classifier_chk

bind fp_operand_classifier fp_classifier_chk u_chk (.clk(clk), .rst_b(rst_b), .operand_valid(operand_valid),
    .operand_format(operand_format), .operand_word(operand_word), .nan_sign(nan_sign), .result_valid(result_valid),
    .sign(sign), .biased_exponent(biased_exponent), .significand(significand), .ext_exponent(ext_exponent),
    .ext_significand(ext_significand), .operand_class(operand_class),
    .is_zero(is_zero), .is_denorm(is_denorm), .is_norm(is_norm), .is_inf(is_inf), .is_trap_nan(is_trap_nan),
    .is_quiet_nan(is_quiet_nan), .sgl_default_nan(sgl_default_nan), .dbl_default_nan(dbl_default_nan));

// ===== test/arith_sink.sv
// stands for the arithmetic datapath: takes every result the classifier delivers
// assumes one result_valid pulse per accepted operand
`timescale 1ns/1ps
module arith_sink (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic result_valid,
    output int        taken
);
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            taken <= 0;
        end else if (result_valid) begin
            taken <= taken + 1;
        end
    end
endmodule // arith_sink

// ===== test/fp_operand_classifier_bench.sv
// self-checking bench for the operand classifier with a result sink
// assumes the package, params header and checker are compiled first
`timescale 1ns/1ps
module fp_operand_classifier_bench;
    import fp_classify_pkg::*;
    logic clk = 0, rst_b = 0, operand_valid = 0, nan_sign = 0, result_valid, sign;
    fp_format_t operand_format = fmt_single;
    logic [63:0] operand_word = 64'h0, ext_significand, dbl_default_nan;
    logic [10:0] biased_exponent;
    logic [52:0] significand;
    logic [14:0] ext_exponent;
    logic [31:0] sgl_default_nan;
    fp_class_t operand_class;
    logic is_zero, is_denorm, is_norm, is_inf, is_trap_nan, is_quiet_nan;
    int fail_count = 0, samples_checked = 0, taken;
    fp_operand_classifier u_dut (
        .clk             (clk),
        .rst_b           (rst_b),
        .operand_valid   (operand_valid),
        .operand_format  (operand_format),
        .operand_word    (operand_word),
        .nan_sign        (nan_sign),
        .result_valid    (result_valid),
        .sign            (sign),
        .biased_exponent (biased_exponent),
        .significand     (significand),
        .ext_exponent    (ext_exponent),
        .ext_significand (ext_significand),
        .operand_class   (operand_class),
        .is_zero         (is_zero),
        .is_denorm       (is_denorm),
        .is_norm         (is_norm),
        .is_inf          (is_inf),
        .is_trap_nan     (is_trap_nan),
        .is_quiet_nan    (is_quiet_nan),
        .sgl_default_nan (sgl_default_nan),
        .dbl_default_nan (dbl_default_nan)
    );
    arith_sink u_sink (.clk(clk), .rst_b(rst_b), .result_valid(result_valid), .taken(taken));
    always #2 clk = ~clk;
    task automatic check(input logic [63:0] seen, input logic [63:0] want);
        samples_checked++;
        if (seen !== want) begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    // one operand, then an idle cycle so unchanged data can be seen holding
    task automatic put(input fp_format_t f, input logic [63:0] w, input fp_class_t c);
        logic [10:0] e;
        logic        h;
        logic [14:0] x;
        logic [63:0] j;
        e = f ? w[62:52] : {3'h0, w[30:23]};
        h = f ? (e != 11'h0 && e != 11'h7ff) : (e != 11'h0 && e != 11'h0ff);
        // widened exponent: zero stays 0, inf and NaN saturate, denormals count as exponent 1
        x = (c == class_zero) ? 15'h0000 :
            (c == class_inf || c == class_trap_nan || c == class_quiet_nan) ? 15'h7fff :
            15'(((e == 11'h0) ? 11'h001 : e) + 15'd16383 - (f ? 15'd1023 : 15'd127));
        j = f ? {h, w[51:0], 11'h000} : {h, w[22:0], 40'h0};
        @(posedge clk);
        operand_valid  <= 1'b1;
        operand_format <= f;
        operand_word   <= w;
        nan_sign       <= w[0];
        @(posedge clk);
        operand_valid <= 1'b0;
        #1;
        check({is_quiet_nan, is_trap_nan, is_inf, is_norm, is_denorm, is_zero}, 64'h1 << c);
        check(ext_exponent, x);
        check(ext_significand, j);
        check(dbl_default_nan, {w[0], 63'h7fff_ffff_ffff_ffff});
        check(result_valid, 1'b1);
        check(operand_class, c);
        check(sign, f ? w[63] : w[31]);
        check(biased_exponent, e);
        check(significand, f ? {h, w[51:0]} : {h, w[22:0], 29'h0});
        check(sgl_default_nan, {w[0], 31'h7fff_ffff});
    endtask
    task automatic test_single;
        put(fmt_single, 64'ha5a5a5a5_3f800000, class_norm);
        put(fmt_single, 64'h0000_0000_7f7f_ffff, class_norm);
        put(fmt_single, 64'h0000_0000_0000_0001, class_denorm);
        put(fmt_single, 64'hffff_ffff_0000_0000, class_zero);
        put(fmt_single, 64'h0000_0000_8000_0000, class_zero);
        put(fmt_single, 64'h0000_0000_ff80_0000, class_inf);
        put(fmt_single, 64'h0000_0000_7f80_0001, class_trap_nan);
        put(fmt_single, 64'h0000_0000_7fc0_0000, class_quiet_nan);
        $display("single format test done");
    endtask
    task automatic test_double;
        put(fmt_double, 64'h3ff0_0000_0000_0000, class_norm);
        put(fmt_double, 64'h000f_ffff_ffff_ffff, class_denorm);
        put(fmt_double, 64'h8000_0000_0000_0000, class_zero);
        put(fmt_double, 64'h7ff0_0000_0000_0000, class_inf);
        put(fmt_double, 64'h7ff0_0000_0000_0001, class_trap_nan);
        put(fmt_double, 64'hfff8_0000_0000_0000, class_quiet_nan);
        @(posedge clk);
        #1;
        check(taken, 14);
        $display("double format test done");
    endtask
    // reset in mid-run with the sign input high: outputs go back to reset values and the
    // default NaN takes the sign again only after release
    task automatic test_reset;
        @(posedge clk);
        nan_sign <= 1'b1;
        rst_b    <= 1'b0;
        @(posedge clk);
        #1;
        check(result_valid, 1'b0);
        check(is_zero, 1'b1);
        check(significand, 53'h0);
        check(ext_exponent, 15'h0000);
        check(sgl_default_nan, 32'h7fff_ffff);
        check(dbl_default_nan, 64'h7fff_ffff_ffff_ffff);
        @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        #1;
        check(sgl_default_nan, 32'hffff_ffff);
        check(taken, 0);
        put(fmt_double, 64'h8010_0000_0000_0000, class_norm);
        $display("mid-run reset test done");
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        test_single;
        test_double;
        test_reset;
        report_and_stop;
    end
    // the whole run needs well under a microsecond
    initial begin
        #20000;
        fail_count++;
        report_and_stop;
    end
endmodule // fp_operand_classifier_bench
